// ---- include/timer_regs.vh ----
// register map, field positions, reset values and encodings of the
// 16-bit match/pwm timer
// assumes byte addresses on a 32-bit avalon-mm bus, one register a word
`ifndef TIMER_REGS_VH
`define TIMER_REGS_VH

// register byte addresses
`define ADDR_INTERRUPT_FLAGS   32'hE007_4000
`define ADDR_TIMER_CONTROL     32'hE007_4004
`define ADDR_COUNT_VALUE       32'hE007_4008
`define ADDR_DIVIDER_LIMIT     32'hE007_400C
`define ADDR_DIVIDER_COUNT     32'hE007_4010
`define ADDR_MATCH_ACTION      32'hE007_4014
`define ADDR_MATCH_VALUE_0     32'hE007_4018
`define ADDR_MATCH_VALUE_1     32'hE007_401C
`define ADDR_MATCH_VALUE_2     32'hE007_4020
`define ADDR_MATCH_VALUE_3     32'hE007_4024
`define ADDR_MATCH_OUTPUT      32'hE007_403C
`define ADDR_COUNT_MODE        32'hE007_4070
`define ADDR_PWM_SELECT        32'hE007_4074

// timer_control fields
`define TCR_ENABLE_BIT         0
`define TCR_RESET_BIT          1

// match_action_control: three bits a channel
`define MCR_INT_BIT            0
`define MCR_RESET_BIT          1
`define MCR_STOP_BIT           2
`define MCR_BITS_PER_CHANNEL   3

// match_output_control: state bits low, two-bit actions from bit 4
`define EMC_FIELD_LSB          4
`define EMC_NOTHING            2'h0
`define EMC_CLEAR              2'h1
`define EMC_SET                2'h2
`define EMC_TOGGLE             2'h3

// count_mode_control encodings
`define MODE_TIMER             2'h0
`define MODE_EXT_RISE          2'h1
`define MODE_EXT_FALL          2'h2
`define MODE_EXT_BOTH          2'h3

// reset values
`define ZERO16                 16'h0000
`define ZERO32                 32'h0000_0000
`define CHANNELS               4

`endif

// ---- hdl/divider_tick.v ----
// programmable divider: counts up to its limit, then clears and ticks
// assumes one clock, synchronous reset and a freezing clock enable
`timescale 1ns/1ps
`include "timer_regs.vh"

module divider_tick
(
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        clear,
  input  wire        advance,
  input  wire [15:0] limit,
  input  wire        load,
  input  wire [15:0] loadValue,
  output reg  [15:0] count,
  output wire        wrap
);

  // terminal count reached on an advancing cycle
  assign wrap = advance & (count == limit);

  // divider counter, bus load overrides counting
  always @(posedge clk)
  begin
    if (rst)
      count <= `ZERO16;
    else if (ce)
    begin
      if (clear)
        count <= `ZERO16;
      else if (load)
        count <= loadValue;
      else if (wrap)
        count <= `ZERO16;
      else if (advance)
        count <= count + 16'h0001;
    end
  end

endmodule

// ---- hdl/match_channel.v ----
// one match channel: compare, match output state and pwm level
// assumes count value and fresh flag come from the same clock domain
`timescale 1ns/1ps
`include "timer_regs.vh"

module match_channel
(
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        countActive,
  input  wire        freshValue,
  input  wire [15:0] countValue,
  input  wire [15:0] matchValue,
  input  wire [1:0]  actionCode,
  input  wire        stateLoad,
  input  wire        stateData,
  output wire        equal,
  output wire        hit,
  output reg         matchState,
  output reg         pwmLevel
);

  wire atZero;

  // compare once per new count value
  assign equal  = (countValue == matchValue);
  assign hit    = countActive & freshValue & equal;
  assign atZero = countActive & freshValue & (countValue == `ZERO16);

  // match state bit and pwm level
  always @(posedge clk)
  begin
    if (rst)
    begin
      matchState <= 1'b0;
      pwmLevel   <= 1'b0;
    end
    else if (ce)
    begin
      if (stateLoad)
        matchState <= stateData;
      else if (hit)
      begin
        case (actionCode)
          `EMC_CLEAR:  matchState <= 1'b0;
          `EMC_SET:    matchState <= 1'b1;
          `EMC_TOGGLE: matchState <= ~matchState;
          default:     matchState <= matchState;
        endcase
      end
      if (atZero)
        pwmLevel <= (matchValue == `ZERO16);
      else if (hit)
        pwmLevel <= 1'b1;
    end
  end

endmodule

// ---- hdl/match_pwm_timer.v ----
// 16-bit timer with divider, four match channels and pwm outputs,
// programmed over an avalon-mm slave with registered waitrequest
// assumes one clock; the external count input is asynchronous
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "timer_regs.vh"

module match_pwm_timer
(
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire [31:0] address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  input  wire        extCountIn,
  output reg  [3:0]  matchOutput
);

////////////////////////////////////////////////////////////////////////
// register state

  reg  [3:0]  interruptFlags;
  reg         counterEnable;
  reg         counterReset;
  reg  [15:0] countValue;
  reg  [15:0] dividerLimit;
  reg  [11:0] matchActionControl;
  reg  [15:0] matchValue [0:3];
  reg  [7:0]  matchOutputAction;
  reg  [1:0]  countModeControl;
  reg  [3:0]  pwmOutputSelect;
  reg         freshValue;

  wire [15:0] dividerCount;
  wire        dividerWrap;
  wire [3:0]  matchEqual;
  wire [3:0]  matchHit;
  wire [3:0]  matchState;
  wire [3:0]  pwmLevel;

////////////////////////////////////////////////////////////////////////
// bus handshake and write decode

  wire        busRequest;
  wire        writeCommit;
  wire [31:0] laneMask;
  wire [31:0] mergedFlags;
  wire [31:0] mergedControl;
  wire [31:0] mergedCount;
  wire [31:0] mergedLimit;
  wire [31:0] mergedDivider;
  wire [31:0] mergedAction;
  wire [31:0] mergedOutput;
  wire [31:0] mergedMode;
  wire [31:0] mergedPwm;
  wire [31:0] mergedMatch [0:3];

  // a request is answered one cycle after it is seen
  assign busRequest  = read | write;
  assign writeCommit = write & ~waitrequest;

  // byte lanes to a bit mask
  assign laneMask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                     {8{byteenable[1]}}, {8{byteenable[0]}}};

  // merge write data into the old value lane by lane
  function [31:0] merge;
    input [31:0] oldValue;
    input [31:0] newValue;
    input [31:0] mask;
    begin
      merge = (oldValue & ~mask) | (newValue & mask);
    end
  endfunction

  // merged words for every writable register but the four match values, which are merged per channel below
  assign mergedFlags   = merge(`ZERO32, writedata, laneMask);
  assign mergedControl = merge({30'h0000_0000, counterReset, counterEnable},
                               writedata, laneMask);
  assign mergedCount   = merge({16'h0000, countValue}, writedata, laneMask);
  assign mergedLimit   = merge({16'h0000, dividerLimit}, writedata, laneMask);
  assign mergedDivider = merge({16'h0000, dividerCount}, writedata, laneMask);
  assign mergedAction  = merge({20'h0_0000, matchActionControl},
                               writedata, laneMask);
  assign mergedOutput  = merge({20'h0_0000, matchOutputAction, matchState},
                               writedata, laneMask);
  assign mergedMode    = merge({30'h0000_0000, countModeControl},
                               writedata, laneMask);
  assign mergedPwm     = merge({28'h000_0000, pwmOutputSelect},
                               writedata, laneMask);

  // write strobes per register
  wire writeFlags;
  wire writeControl;
  wire writeCount;
  wire writeLimit;
  wire writeDivider;
  wire writeAction;
  wire writeOutput;
  wire writeMode;
  wire writePwm;

  assign writeFlags   = writeCommit & (address == `ADDR_INTERRUPT_FLAGS);
  assign writeControl = writeCommit & (address == `ADDR_TIMER_CONTROL);
  assign writeCount   = writeCommit & (address == `ADDR_COUNT_VALUE);
  assign writeLimit   = writeCommit & (address == `ADDR_DIVIDER_LIMIT);
  assign writeDivider = writeCommit & (address == `ADDR_DIVIDER_COUNT);
  assign writeAction  = writeCommit & (address == `ADDR_MATCH_ACTION);
  assign writeOutput  = writeCommit & (address == `ADDR_MATCH_OUTPUT);
  assign writeMode    = writeCommit & (address == `ADDR_COUNT_MODE);
  assign writePwm     = writeCommit & (address == `ADDR_PWM_SELECT);

  // handshake: waitrequest drops for exactly one cycle per request
  always @(posedge clk)
  begin
    if (rst)
      waitrequest <= 1'b1;
    else if (ce)
    begin
      if (busRequest & waitrequest)
        waitrequest <= 1'b0;
      else
        waitrequest <= 1'b1;
    end
  end

////////////////////////////////////////////////////////////////////////
// read side

  reg [31:0] next_readdata;

  // read mux, reserved bits and unmapped addresses read zero
  always @*
  begin
    next_readdata = `ZERO32;
    case (address)
      `ADDR_INTERRUPT_FLAGS: next_readdata = {28'h000_0000, interruptFlags};
      `ADDR_TIMER_CONTROL:   next_readdata = {30'h0000_0000, counterReset,
                                              counterEnable};
      `ADDR_COUNT_VALUE:     next_readdata = {16'h0000, countValue};
      `ADDR_DIVIDER_LIMIT:   next_readdata = {16'h0000, dividerLimit};
      `ADDR_DIVIDER_COUNT:   next_readdata = {16'h0000, dividerCount};
      `ADDR_MATCH_ACTION:    next_readdata = {20'h0_0000, matchActionControl};
      `ADDR_MATCH_VALUE_0:   next_readdata = {16'h0000, matchValue[0]};
      `ADDR_MATCH_VALUE_1:   next_readdata = {16'h0000, matchValue[1]};
      `ADDR_MATCH_VALUE_2:   next_readdata = {16'h0000, matchValue[2]};
      `ADDR_MATCH_VALUE_3:   next_readdata = {16'h0000, matchValue[3]};
      `ADDR_MATCH_OUTPUT:    next_readdata = {20'h0_0000, matchOutputAction,
                                              matchState};
      `ADDR_COUNT_MODE:      next_readdata = {30'h0000_0000, countModeControl};
      `ADDR_PWM_SELECT:      next_readdata = {28'h000_0000, pwmOutputSelect};
      default:               next_readdata = `ZERO32;
    endcase
  end

  // read data captured as waitrequest drops, held until the next answer
  always @(posedge clk)
  begin
    if (rst)
      readdata <= `ZERO32;
    else if (ce)
    begin
      if (read & waitrequest)
        readdata <= next_readdata;
    end
  end

////////////////////////////////////////////////////////////////////////
// external count input: three flip-flops, agreement filter

  reg  extMeta;
  reg  extSync2;
  reg  extSync3;
  reg  extStable;
  wire extAgree;
  wire extRise;
  wire extFall;
  reg  countEvent;

  // synchroniser chain, first stage read only by the second
  always @(posedge clk)
  begin
    if (rst)
    begin
      extMeta   <= 1'b0;
      extSync2  <= 1'b0;
      extSync3  <= 1'b0;
      extStable <= 1'b0;
    end
    else if (ce)
    begin
      extMeta  <= extCountIn;
      extSync2 <= extMeta;
      extSync3 <= extSync2;
      if (extAgree)
        extStable <= extSync3;
    end
  end

  // a level change counts once stages two and three agree
  assign extAgree = (extSync2 == extSync3);
  assign extRise  = extAgree & extSync3 & ~extStable;
  assign extFall  = extAgree & ~extSync3 & extStable;

  // which clocks may advance the divider
  always @*
  begin
    case (countModeControl)
      `MODE_TIMER:    countEvent = 1'b1;
      `MODE_EXT_RISE: countEvent = extRise;
      `MODE_EXT_FALL: countEvent = extFall;
      `MODE_EXT_BOTH: countEvent = extRise | extFall;
      default:        countEvent = 1'b0;
    endcase
  end

////////////////////////////////////////////////////////////////////////
// divider and count value

  wire countActive;
  wire dividerAdvance;
  wire resetOnMatch;
  wire stopOnMatch;
  wire [3:0] resetEnable;
  wire [3:0] stopEnable;
  wire [3:0] interruptEnable;

  // counting runs only while enabled and not held in reset
  assign countActive    = counterEnable & ~counterReset;
  assign dividerAdvance = countActive & countEvent;

  divider_tick u_divider
  (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .clear     (counterReset),
    .advance   (dividerAdvance),
    .limit     (dividerLimit),
    .load      (writeDivider),
    .loadValue (mergedDivider[15:0]),
    .count     (dividerCount),
    .wrap      (dividerWrap)
  );

  // any equal channel with reset enabled clears the count at the wrap
  assign resetOnMatch = |(resetEnable & matchEqual);
  assign stopOnMatch  = |(stopEnable & matchHit);

  // count value: reset hold, bus load, advance; fresh marks a new value
  always @(posedge clk)
  begin
    if (rst)
    begin
      countValue <= `ZERO16;
      freshValue <= 1'b1;
    end
    else if (ce)
    begin
      if (counterReset)
      begin
        countValue <= `ZERO16;
        freshValue <= 1'b1;
      end
      else if (writeCount)
      begin
        countValue <= mergedCount[15:0];
        freshValue <= 1'b1;
      end
      else if (dividerWrap & ~stopOnMatch)
      begin
        if (resetOnMatch)
          countValue <= `ZERO16;
        else
          countValue <= countValue + 16'h0001;
        freshValue <= 1'b1;
      end
      else if (countActive)
        freshValue <= 1'b0;
    end
  end

////////////////////////////////////////////////////////////////////////
// match channels

  genvar ch;
  generate
    for (ch = 0; ch < `CHANNELS; ch = ch + 1)
    begin : gen_channel
      // per-channel action bits
      assign interruptEnable[ch] =
        matchActionControl[ch * `MCR_BITS_PER_CHANNEL + `MCR_INT_BIT];
      assign resetEnable[ch] =
        matchActionControl[ch * `MCR_BITS_PER_CHANNEL + `MCR_RESET_BIT];
      assign stopEnable[ch] =
        matchActionControl[ch * `MCR_BITS_PER_CHANNEL + `MCR_STOP_BIT];

      match_channel u_channel
      (
        .clk         (clk),
        .rst         (rst),
        .ce          (ce),
        .countActive (countActive),
        .freshValue  (freshValue),
        .countValue  (countValue),
        .matchValue  (matchValue[ch]),
        .actionCode  (matchOutputAction[2 * ch + 1:2 * ch]),
        .stateLoad   (writeOutput),
        .stateData   (mergedOutput[ch]),
        .equal       (matchEqual[ch]),
        .hit         (matchHit[ch]),
        .matchState  (matchState[ch]),
        .pwmLevel    (pwmLevel[ch])
      );

      // match value register, lanes merged into the held value
      assign mergedMatch[ch] = merge({16'h0000, matchValue[ch]}, writedata, laneMask);
      always @(posedge clk)
      begin
        if (rst)
          matchValue[ch] <= `ZERO16;
        else if (ce)
        begin
          if (writeCommit & (address == `ADDR_MATCH_VALUE_0 + 4 * ch))
            matchValue[ch] <= mergedMatch[ch][15:0];
        end
      end

      // sticky flag: hardware set wins over the write-one clear
      always @(posedge clk)
      begin
        if (rst)
          interruptFlags[ch] <= 1'b0;
        else if (ce)
        begin
          if (matchHit[ch] & interruptEnable[ch])
            interruptFlags[ch] <= 1'b1;
          else if (writeFlags & mergedFlags[ch])
            interruptFlags[ch] <= 1'b0;
        end
      end

      // pin-less output: pwm level or match state bit
      always @(posedge clk)
      begin
        if (rst)
          matchOutput[ch] <= 1'b0;
        else if (ce)
          matchOutput[ch] <= pwmOutputSelect[ch] ? pwmLevel[ch]
                                                 : matchState[ch];
      end
    end
  endgenerate

////////////////////////////////////////////////////////////////////////
// control and configuration registers

  // timer control: stop on match clears the enable bit
  always @(posedge clk)
  begin
    if (rst)
    begin
      counterEnable <= 1'b0;
      counterReset  <= 1'b0;
    end
    else if (ce)
    begin
      if (writeControl)
      begin
        counterEnable <= mergedControl[`TCR_ENABLE_BIT];
        counterReset  <= mergedControl[`TCR_RESET_BIT];
      end
      if (stopOnMatch)
        counterEnable <= 1'b0;
    end
  end

  // plain configuration words
  always @(posedge clk)
  begin
    if (rst)
    begin
      dividerLimit       <= `ZERO16;
      matchActionControl <= 12'h000;
      matchOutputAction  <= 8'h00;
      countModeControl   <= `MODE_TIMER;
      pwmOutputSelect    <= 4'h0;
    end
    else if (ce)
    begin
      if (writeLimit)
        dividerLimit <= mergedLimit[15:0];
      if (writeAction)
        matchActionControl <= mergedAction[11:0];
      if (writeOutput)
        matchOutputAction <= mergedOutput[11:`EMC_FIELD_LSB];
      if (writeMode)
        countModeControl <= mergedMode[1:0];
      if (writePwm)
        pwmOutputSelect <= mergedPwm[3:0];
    end
  end

endmodule

// ---- testbench/match_pwm_timer_checker.sv ----
// checker: bus handshake, reset state and read-back widths of the timer
// assumes the timer top ports, one clock, synchronous active-high reset
`timescale 1ns/1ps
`include "timer_regs.vh"

module match_pwm_timer_checker
(
  input wire        clk,
  input wire        rst,
  input wire        ce,
  input wire [31:0] address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [3:0]  byteenable,
  input wire [31:0] readdata,
  input wire        waitrequest,
  input wire        extCountIn,
  input wire [3:0]  matchOutput
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////
  // a read of one place, taken and then answered
  sequence sReadOf(logic [31:0] a);
    ce && read && waitrequest && address == a ##1 !waitrequest;
  endsequence

  // bits under the mask come back as zero
  property pZeroBits(logic [31:0] a, logic [31:0] m);
    sReadOf(a) |-> (readdata & m) == 32'h0000_0000;
  endproperty

  ////////////////////////////////////////
  // reset state and handshake timing
  AST_RESET: assert property (disable iff (1'b0)
    rst && ce |=> matchOutput == 4'h0 && waitrequest && readdata == 32'h0000_0000)
    else $error("state not cleared by reset");
  AST_ANSWER: assert property ((read || write) && waitrequest && ce |=> !waitrequest)
    else $error("request not answered next cycle");
  AST_ONE_CYCLE: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  AST_IDLE: assert property (ce && !read && !write && waitrequest |=> waitrequest)
    else $error("answer without request");

  // reserved and unused bits
  AST_FLAG_RSVD: assert property (pZeroBits(`ADDR_INTERRUPT_FLAGS, 32'hFFFF_FFF0))
    else $error("reserved flag bits set");
  AST_TCR_RSVD: assert property (pZeroBits(`ADDR_TIMER_CONTROL, 32'hFFFF_FFFC))
    else $error("reserved control bits set");
  AST_COUNT_16: assert property (pZeroBits(`ADDR_COUNT_VALUE, 32'hFFFF_0000))
    else $error("count wider than 16 bits");
  AST_MCR_RSVD: assert property (pZeroBits(`ADDR_MATCH_ACTION, 32'hFFFF_F000))
    else $error("reserved action bits set");
  AST_EMR_RSVD: assert property (pZeroBits(`ADDR_MATCH_OUTPUT, 32'hFFFF_F000))
    else $error("reserved output control bits set");
  AST_PWM_RSVD: assert property (pZeroBits(`ADDR_PWM_SELECT, 32'hFFFF_FFF0))
    else $error("reserved pwm select bits set");
  AST_UNMAPPED: assert property (pZeroBits(32'hE007_4028, 32'hFFFF_FFFF))
    else $error("unmapped place not zero");
endmodule

// ---- testbench/tb_top.sv ----
// testbench: registers, stop and actions, pwm and external counting
// assumes the timer top, its header, and the checker bound at the foot
`timescale 1ns/1ps
`include "timer_regs.vh"

module tb_top;
  logic        clk;
  logic        rst;
  logic        ce;
  logic [31:0] address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [3:0]  byteenable;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        extCountIn;
  logic [3:0]  matchOutput;
  integer      failCount = 0;
  integer      cmpCount = 0;
  integer      cyc = 0;
  integer      hiCnt [0:3];
  logic [31:0] regAddr [0:12] = '{`ADDR_INTERRUPT_FLAGS, `ADDR_TIMER_CONTROL,
    `ADDR_COUNT_VALUE, `ADDR_DIVIDER_LIMIT, `ADDR_DIVIDER_COUNT, `ADDR_MATCH_ACTION,
    `ADDR_MATCH_VALUE_0, `ADDR_MATCH_VALUE_1, `ADDR_MATCH_VALUE_2, `ADDR_MATCH_VALUE_3,
    `ADDR_MATCH_OUTPUT, `ADDR_COUNT_MODE, `ADDR_PWM_SELECT};
  logic [31:0] regMask [0:12] = '{32'h0000_0000, 32'h0000_0003, 32'h0000_FFFF,
    32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_0FFF, 32'h0000_FFFF, 32'h0000_FFFF,
    32'h0000_FFFF, 32'h0000_FFFF, 32'h0000_0FFF, 32'h0000_0003, 32'h0000_000F};

  ////////////////////////////////////////
  // device under test
  match_pwm_timer dut_u
  (
    .clk(clk), .rst(rst), .ce(ce), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .extCountIn(extCountIn), .matchOutput(matchOutput)
  );

  // clock and cycle ceiling
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failCount = failCount + 1;
      endOfTest;
    end
  end

  ////////////////////////////////////////
  // verdict and compare helpers
  task endOfTest;
  begin
    if (failCount == 0 && cmpCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
  begin
    cmpCount = cmpCount + 1;
    if (got !== exp)
    begin
      failCount = failCount + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask

  // avalon cycles: hold until waitrequest low, release one edge later
  task busWrite(input [31:0] a, input [31:0] d, input [3:0] be);
  begin
    address <= a;
    writedata <= d;
    byteenable <= be;
    write <= 1'b1;
    @(posedge clk);
    while (waitrequest !== 1'b0)
      @(posedge clk);
    write <= 1'b0;
    @(posedge clk);
  end
  endtask
  task wr(input [31:0] a, input [31:0] d);
  begin
    busWrite(a, d, 4'hF);
  end
  endtask
  task busRead(input [31:0] a, output [31:0] d);
  begin
    address <= a;
    read <= 1'b1;
    @(posedge clk);
    while (waitrequest !== 1'b0)
      @(posedge clk);
    d = readdata;
    read <= 1'b0;
    @(posedge clk);
  end
  endtask
  task rdChk(input [31:0] a, input [31:0] exp);
    logic [31:0] v;
  begin
    busRead(a, v);
    chk(v, exp);
  end
  endtask

  ////////////////////////////////////////
  // reset values, read-back widths, unmapped place, byte lanes
  task testRegs;
    integer i;
  begin
    for (i = 0; i < 13; i = i + 1)
      rdChk(regAddr[i], 32'h0000_0000);
    for (i = 0; i < 13; i = i + 1)
    begin
      wr(regAddr[i], 32'hFFFF_FFFF);
      rdChk(regAddr[i], regMask[i]);
      if (i == 10)
        chk(matchOutput, 32'h0000_000F);
      wr(regAddr[i], 32'h0000_0000);
    end
    wr(32'hE007_4028, 32'hFFFF_FFFF);
    rdChk(32'hE007_4028, 32'h0000_0000);
    busWrite(`ADDR_MATCH_VALUE_1, 32'h0000_ABCD, 4'h1);
    rdChk(`ADDR_MATCH_VALUE_1, 32'h0000_00CD);
  end
  endtask

  // stop on match 3 with a different output action on each channel
  task testStop;
    logic [31:0] v;
    integer      k;
    integer      t0;
  begin
    wr(`ADDR_TIMER_CONTROL, 32'h0000_0002);
    rdChk(`ADDR_COUNT_VALUE, 32'h0000_0000);
    wr(`ADDR_DIVIDER_LIMIT, 32'h0000_0002);
    for (k = 0; k < 3; k = k + 1)
      wr(`ADDR_MATCH_VALUE_0 + 4 * k, 32'h0000_0002);
    wr(`ADDR_MATCH_VALUE_3, 32'h0000_000A);
    wr(`ADDR_MATCH_ACTION, 32'h0000_0A49);
    wr(`ADDR_MATCH_OUTPUT, 32'h0000_0D85);
    t0 = cyc;
    wr(`ADDR_TIMER_CONTROL, 32'h0000_0001);
    v = 32'h0000_0000;
    while (v[3] !== 1'b1 && cyc - t0 < 200)
      busRead(`ADDR_INTERRUPT_FLAGS, v);
    chk(v, 32'h0000_000F);
    chk({31'h0, cyc - t0 >= 28 && cyc - t0 <= 42}, 32'h0000_0001);
    rdChk(`ADDR_TIMER_CONTROL, 32'h0000_0000);
    rdChk(`ADDR_COUNT_VALUE, 32'h0000_000A);
    chk(matchOutput, 32'h0000_000B);
    rdChk(`ADDR_MATCH_OUTPUT, 32'h0000_0D8B);
    wr(`ADDR_INTERRUPT_FLAGS, 32'h0000_0000);
    rdChk(`ADDR_INTERRUPT_FLAGS, 32'h0000_000F);
    wr(`ADDR_INTERRUPT_FLAGS, 32'h0000_0008);
    rdChk(`ADDR_INTERRUPT_FLAGS, 32'h0000_0007);
    wr(`ADDR_INTERRUPT_FLAGS, 32'h0000_0007);
    rdChk(`ADDR_INTERRUPT_FLAGS, 32'h0000_0000);
  end
  endtask

  // settle, then count high samples of each output over five periods
  task measure;
    integer n;
    integer b;
  begin
    repeat (30) @(posedge clk);
    for (b = 0; b < 4; b = b + 1)
      hiCnt[b] = 0;
    for (n = 0; n < 55; n = n + 1)
    begin
      @(posedge clk);
      for (b = 0; b < 4; b = b + 1)
        hiCnt[b] = hiCnt[b] + matchOutput[b];
    end
  end
  endtask

  // pwm on all outputs, cycle length 11 set by match 3 at 10
  task testPwm;
  begin
    wr(`ADDR_TIMER_CONTROL, 32'h0000_0002);
    wr(`ADDR_DIVIDER_LIMIT, 32'h0000_0000);
    wr(`ADDR_MATCH_VALUE_0, 32'h0000_0004);
    wr(`ADDR_MATCH_VALUE_1, 32'h0000_0014);
    wr(`ADDR_MATCH_VALUE_2, 32'h0000_0000);
    wr(`ADDR_MATCH_ACTION, 32'h0000_0400);
    wr(`ADDR_MATCH_OUTPUT, 32'h0000_0000);
    wr(`ADDR_PWM_SELECT, 32'h0000_000F);
    wr(`ADDR_TIMER_CONTROL, 32'h0000_0001);
    measure;
    chk(hiCnt[0], 32'h0000_0023);
    chk(hiCnt[1], 32'h0000_0000);
    chk(hiCnt[2], 32'h0000_0037);
    chk(hiCnt[3], 32'h0000_0005);
    wr(`ADDR_MATCH_VALUE_0, 32'h0000_0014);
    measure;
    chk(hiCnt[0], 32'h0000_0000);
    wr(`ADDR_MATCH_VALUE_0, 32'h0000_000A);
    measure;
    chk(hiCnt[0], 32'h0000_0005);
    wr(`ADDR_TIMER_CONTROL, 32'h0000_0000);
    wr(`ADDR_PWM_SELECT, 32'h0000_0000);
  end
  endtask

  // external count source on rising, falling and both edges
  task testExt;
    integer m;
    integer p;
  begin
    wr(`ADDR_MATCH_ACTION, 32'h0000_0000);
    for (m = 1; m < 4; m = m + 1)
    begin
      wr(`ADDR_TIMER_CONTROL, 32'h0000_0002);
      wr(`ADDR_COUNT_MODE, m);
      wr(`ADDR_TIMER_CONTROL, 32'h0000_0001);
      for (p = 0; p < 5; p = p + 1)
      begin
        extCountIn <= 1'b1;
        repeat (4) @(posedge clk);
        extCountIn <= 1'b0;
        repeat (4) @(posedge clk);
      end
      repeat (6) @(posedge clk);
      rdChk(`ADDR_COUNT_VALUE, (m == 3) ? 32'h0000_000A : 32'h0000_0005);
    end
    wr(`ADDR_COUNT_MODE, 32'h0000_0000);
  end
  endtask

  ////////////////////////////////////////
  // reset, then the scenarios in turn
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    address = 32'h0000_0000;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
    byteenable = 4'hF;
    extCountIn = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    testRegs;
    testStop;
    testPwm;
    testExt;
    endOfTest;
  end
endmodule

// checker on the timer's ports
bind match_pwm_timer match_pwm_timer_checker chk_u
(
  .clk(clk), .rst(rst), .ce(ce), .address(address), .read(read),
  .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest),
  .extCountIn(extCountIn), .matchOutput(matchOutput)
);
